// ---- core/switch_host_port_reset.sv ----
`timescale 1ns/1ns
`include "switch_host_port_regs.svh"
// Behaviour
// - Any reset restores register defaults and opens every analog switch path.
// - After reset the device sits in standby, ready to detect accessories.
// - First rising edge of bus or battery supply causes a power-on reset.
// - A falling edge of the host I/O supply resets the device.
// - Both bus lines low 30 ms with I/O supply valid resets; high restarts.
// - Writing the reset bit at offset 0x1b gives a full reset.
// - Fast-mode serial target, clock up to 400 kHz.
// - Answers only target address 0100101; bit 0 selects read or write.
// - Serial port and interrupt only with valid I/O supply; detection otherwise.
// - Status and configuration only through serial register accesses.
// - Active-low interrupt on identification or attach status change.
// - Interrupt held low after reset until control mask bit is cleared.
module switch_host_port_reset import switch_host_port_pkg::*; #(
  parameter int unsigned BUS_LOW_CYCLES = `BUS_LOW_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_supply_in,
  input wire logic battery_supply,
  input wire logic host_io_supply,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic connector_ident_pin,
  input wire logic attach_status,
  output logic irq_out_n,
  output logic switch_paths_closed,
  output logic standby,
  output logic detect_enable,
  output logic device_reset
);
  if (BUS_LOW_CYCLES < 2) begin
    $error("BUS_LOW_CYCLES too small");
  end
  logic vbus_q, vbat_q, vio_q, scl_q, sda_q, pwr_seen_q;
  logic vbus_d, vbat_d, vio_d, scl_d, sda_d, pwr_seen_d;
  logic [31:0] low_cnt_q, low_cnt_d;
  logic soft_rst_q, soft_rst_d;
  logic int_rst;
  bus_state_type st_q, st_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d, ctrl_q, ctrl_d, rst_reg_q, rst_reg_d, tx_q, tx_d;
  logic rw_q, rw_d, have_ptr_q, have_ptr_d, nack_q, nack_d;
  logic [1:0] ident_q, ident_d;
  logic chg_q, chg_d;
  logic sda_out_q, sda_out_d;
  logic scl_rise, scl_fall, start_c, stop_c;
  // Supply edge tracking runs on the external reset only
  always_comb begin
    vbus_d = bus_supply_in;
    vbat_d = battery_supply;
    vio_d = host_io_supply;
    pwr_seen_d = pwr_seen_q | bus_supply_in | battery_supply;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vbus_q <= 1'b0;
      vbat_q <= 1'b0;
      vio_q <= 1'b0;
      pwr_seen_q <= 1'b0;
    end else begin
      vbus_q <= vbus_d;
      vbat_q <= vbat_d;
      vio_q <= vio_d;
      pwr_seen_q <= pwr_seen_d;
    end
  end
  logic por_evt, vio_fall, bus_low_evt;
  assign por_evt = !pwr_seen_q && ((bus_supply_in && !vbus_q) || (battery_supply && !vbat_q));
  assign vio_fall = vio_q && !host_io_supply;
  assign bus_low_evt = host_io_supply && (low_cnt_q >= BUS_LOW_CYCLES - 1) && !scl_in && !sda_in;
  // Bus-low timeout counter
  always_comb begin
    low_cnt_d = 32'h0;
    if (host_io_supply && !scl_in && !sda_in && !bus_low_evt) begin
      low_cnt_d = low_cnt_q + 32'h1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt_q <= 32'h0;
    end else begin
      low_cnt_q <= low_cnt_d;
    end
  end
  assign int_rst = por_evt | vio_fall | bus_low_evt | soft_rst_q;
  assign device_reset = int_rst;

  assign scl_rise = scl_in && !scl_q;
  assign scl_fall = !scl_in && scl_q;
  assign start_c = scl_in && scl_q && sda_q && !sda_in;
  assign stop_c = scl_in && scl_q && !sda_q && sda_in;

  // Serial target: register pointer, then data bytes
  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    ctrl_d = ctrl_q;
    rst_reg_d = rst_reg_q;
    rw_d = rw_q;
    have_ptr_d = have_ptr_q;
    nack_d = nack_q;
    tx_d = tx_q;
    sda_out_d = sda_out_q;
    soft_rst_d = 1'b0;
    scl_d = scl_in;
    sda_d = sda_in;
    if (!host_io_supply) begin
      st_d = st_idle;
      sda_out_d = 1'b1;
    end else if (start_c) begin
      st_d = st_addr;
      bit_d = 4'h0;
      sda_out_d = 1'b1;
    end else if (stop_c) begin
      st_d = st_idle;
      sda_out_d = 1'b1;
    end else begin
      case (st_q)
        st_addr: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_in};
            bit_d = bit_q + 4'h1;
          end
          if (scl_fall && bit_q == 4'h8) begin
            if (sh_q[7:1] == `TARGET_ADDR) begin
              rw_d = sh_q[0];
              have_ptr_d = 1'b0;
              sda_out_d = 1'b0;
              st_d = st_ack;
              if (ptr_q == `CONTROL_OFFSET) tx_d = ctrl_q;
              else if (ptr_q == `RESET_CTRL_OFFSET) tx_d = rst_reg_q;
              else tx_d = 8'h00;
            end else begin
              st_d = st_skip;
            end
          end
        end
        st_ack: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            st_d = st_data;
            sda_out_d = rw_q ? tx_q[7] : 1'b1;
          end
        end
        st_data: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_in};
            bit_d = bit_q + 4'h1;
          end
          if (scl_fall && bit_q != 4'h8 && rw_q) sda_out_d = tx_q[3'h7 - bit_q[2:0]];
          if (scl_fall && bit_q == 4'h8) begin
            st_d = st_dack;
            sda_out_d = rw_q; // Release after a read byte, acknowledge after a written one
            if (!rw_q) begin
              if (!have_ptr_q) begin
                ptr_d = sh_q;
                have_ptr_d = 1'b1;
              end else begin
                if (ptr_q == `CONTROL_OFFSET) ctrl_d = sh_q;
                else if (ptr_q == `RESET_CTRL_OFFSET) begin
                  rst_reg_d = sh_q;
                  soft_rst_d = sh_q[`RESET_CTRL_BIT];
                end
                ptr_d = ptr_q + 8'h1;
              end
            end
          end
        end
        st_dack: begin
          if (scl_rise && rw_q) nack_d = sda_in;
          if (scl_fall) begin
            bit_d = 4'h0;
            if (rw_q && nack_q) begin
              st_d = st_skip;
              sda_out_d = 1'b1;
            end else begin
              st_d = st_data;
              sda_out_d = 1'b1;
              if (rw_q) begin
                ptr_d = ptr_q + 8'h1;
                if (ptr_q + 8'h1 == `CONTROL_OFFSET) tx_d = ctrl_q;
                else if (ptr_q + 8'h1 == `RESET_CTRL_OFFSET) tx_d = rst_reg_q;
                else tx_d = 8'h00;
                sda_out_d = tx_d[7];
              end
            end
          end
        end
        default: sda_out_d = 1'b1;
      endcase
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      soft_rst_q <= 1'b0;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
      soft_rst_q <= soft_rst_d;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= st_idle;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      ctrl_q <= `CONTROL_RESET;
      rst_reg_q <= `RESET_CTRL_RESET;
      rw_q <= 1'b0;
      have_ptr_q <= 1'b0;
      nack_q <= 1'b0;
      tx_q <= 8'h00;
      sda_out_q <= 1'b1;
    end else if (int_rst) begin
      st_q <= st_idle;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      ctrl_q <= `CONTROL_RESET;
      rst_reg_q <= `RESET_CTRL_RESET;
      rw_q <= 1'b0;
      have_ptr_q <= 1'b0;
      nack_q <= 1'b0;
      tx_q <= 8'h00;
      sda_out_q <= 1'b1;
    end else begin
      st_q <= st_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      ctrl_q <= ctrl_d;
      rst_reg_q <= rst_reg_d;
      rw_q <= rw_d;
      have_ptr_q <= have_ptr_d;
      nack_q <= nack_d;
      tx_q <= tx_d;
      sda_out_q <= sda_out_d;
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = !sda_out_q && host_io_supply;
  // Status change interrupt
  always_comb begin
    ident_d = {attach_status, connector_ident_pin};
    chg_d = chg_q;
    if (ident_q != ident_d) chg_d = 1'b1;
    else if (ctrl_q[`CONTROL_INT_MASK_BIT]) chg_d = 1'b0;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ident_q <= 2'b00;
      chg_q <= 1'b0;
    end else if (int_rst) begin
      ident_q <= {attach_status, connector_ident_pin};
      chg_q <= 1'b0;
    end else begin
      ident_q <= ident_d;
      chg_q <= chg_d;
    end
  end
  // Mask set holds the pin low; unmasked it latches low on change until the mask bit is set
  assign irq_out_n = !(host_io_supply && (ctrl_q[`CONTROL_INT_MASK_BIT] || chg_q));
  assign switch_paths_closed = 1'b0;
  assign standby = 1'b1;
  assign detect_enable = bus_supply_in | battery_supply;

  chk_soft_reset: assert property (@(posedge clk) disable iff (rst)
    soft_rst_q |-> device_reset) else $error("soft reset not applied");
  chk_bus_low_rst: assert property (@(posedge clk) disable iff (rst)
    device_reset && host_io_supply && !scl_in && !sda_in && !soft_rst_q && !por_evt |-> $past(!scl_in)) else $error("bus reset bad");
  chk_ctrl_default: assert property (@(posedge clk) disable iff (rst)
    $past(int_rst) |-> ctrl_q == `CONTROL_RESET) else $error("control not default");
  chk_irq_masked: assert property (@(posedge clk) disable iff (rst)
    host_io_supply && ctrl_q[`CONTROL_INT_MASK_BIT] |-> !irq_out_n) else $error("irq not held");
  chk_no_vio_drive: assert property (@(posedge clk) disable iff (rst)
    !host_io_supply |-> !sda_oe && irq_out_n) else $error("drive without supply");
  chk_vio_fall: assert property (@(posedge clk) disable iff (rst)
    $fell(host_io_supply) |-> device_reset) else $error("no vio reset");
  chk_switch_open: assert property (@(posedge clk) disable iff (rst)
    !switch_paths_closed) else $error("switch closed");
  chk_detect_on: assert property (@(posedge clk) disable iff (rst)
    bus_supply_in |-> detect_enable) else $error("detect off");
  cov_addr_ack: cover property (@(posedge clk) st_q == st_ack);
  cov_soft_rst: cover property (@(posedge clk) soft_rst_q);
  cov_bus_low: cover property (@(posedge clk) bus_low_evt);
endmodule

// ---- include/switch_host_port_regs.svh ----
`ifndef SWITCH_HOST_PORT_REGS_SVH
`define SWITCH_HOST_PORT_REGS_SVH
`define TARGET_ADDR 7'h25
`define CONTROL_OFFSET 8'h02
`define RESET_CTRL_OFFSET 8'h1b
`define CONTROL_RESET 8'h1f
`define RESET_CTRL_RESET 8'h00
`define CONTROL_INT_MASK_BIT 0
`define RESET_CTRL_BIT 0
`define BUS_LOW_TIME_MS 30
`define CLK_FREQ_KHZ 100000
`define BUS_LOW_CYCLES (`BUS_LOW_TIME_MS * `CLK_FREQ_KHZ)
`endif

// ---- include/switch_host_port_pkg.sv ----
package switch_host_port_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_addr = 3'b001,
    st_ack  = 3'b011,
    st_data = 3'b010,
    st_dack = 3'b110,
    st_skip = 3'b111
  } bus_state_type;
endpackage

// ---- test/host_bus_model.sv ----
`timescale 1ns/1ns
module host_bus_model (
  input wire logic clk,
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Four clocks a phase, no stretching: the host never parks both lines low by accident
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  task automatic start();
    sda_drv <= 1'b1;
    half();
    scl <= 1'b1;
    half();
    sda_drv <= 1'b0;
    half();
    scl <= 1'b0;
    half();
  endtask
  task automatic stop();
    sda_drv <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda_drv <= 1'b1;
    half();
  endtask
  // Data changes only while the clock is low; sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    half();
    scl <= 1'b1;
    half();
    @(negedge clk) r = sda;
    @(posedge clk) scl <= 1'b0;
    half();
  endtask
  task automatic xfer(input logic [7:0] w, input logic mack, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(w[i], a);
      r[i] = a;
    end
    bit_io(mack, a);
    ack = ~a;
  endtask
  // Both lines held low together for n clocks, then released with a stop
  task automatic hold_low(input int n);
    sda_drv <= 1'b0;
    half();
    scl <= 1'b0;
    repeat (n) @(posedge clk);
    scl <= 1'b1;
    half();
    sda_drv <= 1'b1;
    half();
  endtask
endmodule

// ---- test/tb_switch_host_port_reset.sv ----
`timescale 1ns/1ns
`include "switch_host_port_regs.svh"
module tb_switch_host_port_reset;
  localparam int unsigned LOW_CYC = 50;
  logic clk, rst, bus_supply_in, battery_supply, host_io_supply, connector_ident_pin, attach_status;
  logic scl, sda_drv, sda_out, sda_oe, irq_out_n, switch_paths_closed, standby, detect_enable, device_reset;
  wire sda;
  int bad_count, num_checks, resets, r0;
  logic [7:0] rb;
  logic ack;
  // Open-drain line with pull-up
  assign sda = sda_drv & ~(sda_oe & ~sda_out);
  host_bus_model i_host (.clk(clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));
  switch_host_port_reset #(.BUS_LOW_CYCLES(LOW_CYC)) i_dut (.clk(clk), .rst(rst),
    .bus_supply_in(bus_supply_in), .battery_supply(battery_supply), .host_io_supply(host_io_supply),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .connector_ident_pin(connector_ident_pin), .attach_status(attach_status), .irq_out_n(irq_out_n),
    .switch_paths_closed(switch_paths_closed), .standby(standby), .detect_enable(detect_enable),
    .device_reset(device_reset));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (device_reset === 1'b1) resets++;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] off, input logic [7:0] d, input logic exp);
    i_host.start();
    i_host.xfer({a, 1'b0}, 1'b1, rb, ack);
    chk({7'h00, ack}, {7'h00, exp});
    if (ack) begin
      i_host.xfer(off, 1'b1, rb, ack);
      chk({7'h00, ack}, 8'h01);
      i_host.xfer(d, 1'b1, rb, ack);
    end
    i_host.stop();
  endtask
  task automatic rd(input logic [7:0] off, input logic [7:0] exp);
    i_host.start();
    i_host.xfer({7'h25, 1'b0}, 1'b1, rb, ack);
    i_host.xfer(off, 1'b1, rb, ack);
    i_host.start();
    i_host.xfer({7'h25, 1'b1}, 1'b1, rb, ack);
    i_host.xfer(8'hff, 1'b1, rb, ack);
    i_host.stop();
    chk(rb, exp);
  endtask
  // Two-byte read: the master acknowledges the first byte, so the pointer advances
  task automatic rd2(input logic [7:0] off, input logic [7:0] exp0, input logic [7:0] exp1);
    logic [7:0] rb0;
    i_host.start();
    i_host.xfer({`TARGET_ADDR, 1'b0}, 1'b1, rb, ack);
    i_host.xfer(off, 1'b1, rb, ack);
    i_host.start();
    i_host.xfer({`TARGET_ADDR, 1'b1}, 1'b1, rb, ack);
    i_host.xfer(8'hff, 1'b0, rb0, ack);
    i_host.xfer(8'hff, 1'b1, rb, ack);
    i_host.stop();
    chk(rb0, exp0);
    chk(rb, exp1);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    bus_supply_in = 1'b0;
    battery_supply = 1'b0;
    host_io_supply = 1'b0;
    connector_ident_pin = 1'b0;
    attach_status = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    settle();
    r0 = resets;
    battery_supply <= 1'b1;
    settle();
    chk(8'(resets - r0), 8'h01);
    host_io_supply <= 1'b1;
    settle();
    chk({4'h0, irq_out_n, switch_paths_closed, standby, detect_enable}, 8'h03);
    wr(7'h26, 8'h02, 8'h1e, 1'b0);
    wr(7'h25, 8'h02, 8'h1e, 1'b1);
    rd(8'h02, 8'h1e);
    rd2(8'h01, 8'h00, 8'h1e);
    chk({7'h00, irq_out_n}, 8'h01);
    attach_status <= 1'b1;
    settle();
    chk({7'h00, irq_out_n}, 8'h00);
    wr(7'h25, 8'h02, `CONTROL_RESET, 1'b1);
    wr(7'h25, 8'h02, 8'h1e, 1'b1);
    chk({7'h00, irq_out_n}, 8'h01);
    connector_ident_pin <= 1'b1;
    settle();
    chk({7'h00, irq_out_n}, 8'h00);
    wr(7'h25, 8'h02, 8'h1e, 1'b1);
    r0 = resets;
    wr(7'h25, 8'h1b, 8'h01, 1'b1);
    chk(8'(resets - r0), 8'h01);
    chk({7'h00, irq_out_n}, 8'h00);
    rd(8'h02, `CONTROL_RESET);
    wr(7'h25, 8'h02, 8'h1e, 1'b1);
    r0 = resets;
    i_host.hold_low(LOW_CYC - 10);
    i_host.hold_low(LOW_CYC - 10);
    chk(8'(resets - r0), 8'h00);
    i_host.hold_low(LOW_CYC + 10);
    chk(8'(resets - r0), 8'h01);
    rd(8'h02, `CONTROL_RESET);
    r0 = resets;
    host_io_supply <= 1'b0;
    settle();
    chk(8'(resets - r0), 8'h01);
    chk({6'h00, irq_out_n, detect_enable}, 8'h03);
    wr(7'h25, 8'h02, 8'h1e, 1'b0);
    host_io_supply <= 1'b1;
    settle();
    rd(8'h02, `CONTROL_RESET);
    conclude();
  end
  initial begin
    #300000;
    bad_count++;
    $display("ERROR %0t: run did not finish", $time);
    conclude();
  end
endmodule
